// >>> logic/lip_ctrl.sv
module lip_ctrl #(
  parameter int ROWS     = lip_pkg::DUTY_ROWS,
  parameter int BUSY_LEN = lip_pkg::BUSY_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       bus_wr,
  input  wire logic       bus_rd,
  input  wire logic       register_select,
  input  wire logic [7:0] bus_wdata,
  output logic [7:0]      bus_rdata,
  output logic            instr_valid,
  output logic            instr_rs,
  output logic [7:0]      instr_data,
  output logic            iface_8bit,
  output logic            powerdown_bit,
  output logic [3:0]      contrast_step,
  output logic            main_osc_clk,
  output logic            sub_osc_clk,
  output logic            drive_enable,
  output logic            char_icon_enable,
  output logic            static_seg_enable,
  output logic            mem_hold,
  output logic [4:0]      com_row,
  output logic            frame_start,
  output logic [6:0]      bias_ratio_x10
);
  lip_pkg::lip_mode_t mode_q, mode_d;
  logic       if8_q, if8_d;
  logic       pd_q, pd_d;
  logic [3:0] con_q, con_d;
  logic       half_q, half_d;
  logic [3:0] hi_q, hi_d;
  logic       iv_q, iv_d;
  logic       irs_q, irs_d;
  logic [7:0] idat_q, idat_d;
  logic [7:0] rd_q, rd_d;
  logic       rd_half_q, rd_half_d;
  logic [3:0] busy_q, busy_d;
  logic [6:0] ac_q, ac_d;
  logic       full_valid;
  logic [7:0] full_byte;
  logic       run_main;
  logic       main_tick;

  function automatic logic is_fset(input logic [7:0] b);
    return (b & lip_pkg::FS_MASK) == lip_pkg::FS_CODE;
  endfunction

  function automatic logic is_ccon(input logic [7:0] b);
    return (b & lip_pkg::CC_MASK) == lip_pkg::CC_CODE;
  endfunction

  // assemble a byte: direct in 8-bit mode, two nibbles otherwise
  always_comb begin
    half_d     = half_q;
    hi_d       = hi_q;
    full_valid = 1'b0;
    full_byte  = bus_wdata;
    if (bus_wr) begin
      if (if8_q) begin
        full_valid = 1'b1;
        half_d     = 1'b0;
      end else if (!half_q) begin
        hi_d   = bus_wdata[7:4];
        half_d = 1'b1;
      end else begin
        full_byte  = {hi_q, bus_wdata[7:4]};
        full_valid = 1'b1;
        half_d     = 1'b0;
      end
    end
  end

  // decode instructions; port stays alive in power-down
  always_comb begin
    if8_d  = if8_q;
    pd_d   = pd_q;
    con_d  = con_q;
    mode_d = mode_q;
    iv_d   = 1'b0;
    irs_d  = irs_q;
    idat_d = idat_q;
    busy_d = (busy_q != 4'h0) ? busy_q - 4'h1 : 4'h0;
    ac_d   = ac_q;
    if (full_valid) begin
      iv_d   = 1'b1;
      irs_d  = register_select;
      idat_d = full_byte;
      busy_d = 4'(BUSY_LEN);
      if (!register_select && is_fset(full_byte)) begin
        if8_d = full_byte[lip_pkg::FS_DL_BIT];
        pd_d  = full_byte[lip_pkg::FS_PD_BIT];
        mode_d = full_byte[lip_pkg::FS_PD_BIT] ? lip_pkg::LIP_RUN
                                               : lip_pkg::LIP_PWR_DOWN;
      end else if (!register_select && is_ccon(full_byte)) begin
        con_d = full_byte[3:0];
      end else if (!register_select && full_byte[7]) begin
        ac_d = full_byte[6:0];
      end else if (register_select) begin
        ac_d = ac_q + 7'h01;
      end
    end
  end

  // status read: busy flag and address, twice in 4-bit mode
  always_comb begin
    rd_d      = 8'h00;
    rd_half_d = rd_half_q;
    if (bus_rd) begin
      if (if8_q) begin
        rd_d      = {(busy_q != 4'h0), ac_q};
        rd_half_d = 1'b0;
      end else begin
        rd_d      = rd_half_q ? {ac_q[3:0], 4'h0} : {(busy_q != 4'h0), ac_q[6:4], 4'h0};
        rd_half_d = ~rd_half_q;
      end
    end
  end

  // nibble assembly state; a reset mid-transfer drops a lone upper half
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      half_q <= 1'h0;
      hi_q   <= 4'h0;
    end else begin
      half_q <= half_d;
      hi_q   <= hi_d;
    end
  end

  // executed instruction and configuration state
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= lip_pkg::LIP_RUN;
      if8_q  <= lip_pkg::RST_IF_8BIT;
      pd_q   <= lip_pkg::RST_PWR_NORMAL;
      con_q  <= lip_pkg::RST_CONTRAST;
      iv_q   <= 1'h0;
      irs_q  <= 1'h0;
      idat_q <= 8'h00;
      busy_q <= 4'h0;
      ac_q   <= 7'h00;
    end else begin
      mode_q <= mode_d;
      if8_q  <= if8_d;
      pd_q   <= pd_d;
      con_q  <= con_d;
      iv_q   <= iv_d;
      irs_q  <= irs_d;
      idat_q <= idat_d;
      busy_q <= busy_d;
      ac_q   <= ac_d;
    end
  end

  // status read state, kept apart so reads never disturb instruction state
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_q      <= 8'h00;
      rd_half_q <= 1'h0;
    end else begin
      rd_q      <= rd_d;
      rd_half_q <= rd_half_d;
    end
  end

  assign run_main = (mode_q == lip_pkg::LIP_RUN);

  // main oscillator, 145 kHz equivalent
  lip_clkdiv #(.HALF(lip_pkg::OSC_HALF_CYC)) u_main_osc (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .run      (run_main),
    .osc_out  (main_osc_clk),
    .osc_tick (main_tick)
  );

  // sub oscillator only runs in power-down, for the static segment
  lip_clkdiv #(.HALF(lip_pkg::SUB_HALF_CYC)) u_sub_osc (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .run      (!run_main),
    .osc_out  (sub_osc_clk),
    .osc_tick ()
  );

  // row scan holds row 0 while blanked
  lip_rowscan #(.ROWS(ROWS)) u_scan (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .tick        (main_tick),
    .blank       (!run_main),
    .row_idx     (com_row),
    .frame_start (frame_start)
  );

  assign bus_rdata         = rd_q;
  assign instr_valid       = iv_q;
  assign instr_rs          = irs_q;
  assign instr_data        = idat_q;
  assign iface_8bit        = if8_q;
  assign powerdown_bit     = pd_q;
  assign contrast_step     = con_q;
  assign drive_enable      = run_main;
  assign char_icon_enable  = run_main;
  assign static_seg_enable = 1'b1;
  assign mem_hold          = !run_main;
  assign bias_ratio_x10    = 7'(lip_pkg::BIAS_X10);
endmodule

// >>> logic/lip_pkg.sv
package lip_pkg;
  // interface width after reset
  localparam logic RST_IF_8BIT     = 1'h1;
  // power-down bit after reset: normal operation
  localparam logic RST_PWR_NORMAL  = 1'h1;
  localparam logic [3:0] RST_CONTRAST = 4'h0;
  // instruction field positions
  localparam int   FS_DL_BIT       = 4;
  localparam int   FS_PD_BIT       = 2;
  localparam logic [7:0] FS_MASK   = 8'hE0;
  localparam logic [7:0] FS_CODE   = 8'h20;
  localparam logic [7:0] CC_MASK   = 8'hF0;
  localparam logic [7:0] CC_CODE   = 8'h40;
  // oscillator and drive timing
  localparam int   CORE_CLK_HZ     = 10_000_000;
  localparam int   OSC_HZ          = 145_000;
  localparam int   OSC_HALF_CYC    = CORE_CLK_HZ / (2 * OSC_HZ);
  localparam int   SUB_HALF_CYC    = 8 * OSC_HALF_CYC;
  localparam int   DUTY_ROWS       = 28;
  localparam int   BIAS_X10        = 63;
  // cycles the busy flag stays up after an executed instruction
  localparam int   BUSY_CYC        = 4;
  typedef enum logic [1:0] {LIP_RUN, LIP_PWR_DOWN} lip_mode_t;
endpackage

// >>> logic/lip_clkdiv.sv
// square-wave clock-enable generator for the main or sub oscillator
module lip_clkdiv #(
  parameter int HALF = 34
) (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic run,
  output logic      osc_out,
  output logic      osc_tick
);
  logic [15:0] cnt_q, cnt_d;
  logic        osc_q, osc_d;

  // stopping resets the phase so a restart is clean
  always_comb begin
    cnt_d = cnt_q;
    osc_d = osc_q;
    if (!run) begin
      cnt_d = 16'h0000;
      osc_d = 1'b0;
    end else if (cnt_q == 16'(HALF - 1)) begin
      cnt_d = 16'h0000;
      osc_d = ~osc_q;
    end else begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 16'h0000;
      osc_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      osc_q <= osc_d;
    end
  end

  assign osc_out  = osc_q;
  assign osc_tick = run && (cnt_q == 16'(HALF - 1)) && osc_q;
endmodule

// >>> logic/lip_rowscan.sv
// common row scanner, one row per main oscillator period
module lip_rowscan #(
  parameter int ROWS = 28
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       tick,
  input  wire logic       blank,
  output logic [4:0]      row_idx,
  output logic            frame_start
);
  logic [4:0] row_q, row_d;

  always_comb begin
    row_d = row_q;
    if (blank) begin
      row_d = 5'h00;
    end else if (tick) begin
      row_d = (row_q == 5'(ROWS - 1)) ? 5'h00 : row_q + 5'h01;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      row_q <= 5'h00;
    end else begin
      row_q <= row_d;
    end
  end

  assign row_idx     = row_q;
  assign frame_start = tick && (row_q == 5'(ROWS - 1));
endmodule

// >>> tb/lip_ctrl_sva.sv
module lip_ctrl_sva (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       instr_valid,
  input wire logic [7:0] instr_data,
  input wire logic       iface_8bit,
  input wire logic       powerdown_bit,
  input wire logic [3:0] contrast_step,
  input wire logic       main_osc_clk,
  input wire logic       sub_osc_clk,
  input wire logic       drive_enable,
  input wire logic       char_icon_enable,
  input wire logic       mem_hold
);
  timeunit 1ns;
  timeprecision 1ns;
  // one domain; nothing is judged while reset holds
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  chk_width_reset: assert property ($fell(sys_rst) |-> iface_8bit)
    else $error("width not 8-bit after reset");
  chk_blank_drive: assert property (drive_enable == powerdown_bit && char_icon_enable == powerdown_bit)
    else $error("drive enables not tied to power-down");
  chk_mem_keep: assert property (mem_hold == !powerdown_bit)
    else $error("memory hold wrong");
  chk_main_halt: assert property (!powerdown_bit [*3] |-> !main_osc_clk)
    else $error("main oscillator runs in power-down");
  chk_sub_idle: assert property (powerdown_bit [*3] |-> !sub_osc_clk)
    else $error("sub oscillator runs in normal mode");
  chk_pd_source: assert property ($changed(powerdown_bit) |-> instr_valid &&
    instr_data[7:5] == 3'h1 && instr_data[2] == powerdown_bit) else $error("power-down moved without function set");
  chk_width_source: assert property ($changed(iface_8bit) |-> instr_valid &&
    instr_data[7:5] == 3'h1 && instr_data[4] == iface_8bit) else $error("width moved without function set");
  chk_contrast_load: assert property ($changed(contrast_step) |-> instr_valid &&
    instr_data[7:4] == 4'h4 && contrast_step == instr_data[3:0]) else $error("contrast moved wrongly");
endmodule

bind lip_ctrl lip_ctrl_sva i_lip_ctrl_sva (.core_clk(core_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
  .instr_data(instr_data), .iface_8bit(iface_8bit), .powerdown_bit(powerdown_bit), .contrast_step(contrast_step),
  .main_osc_clk(main_osc_clk), .sub_osc_clk(sub_osc_clk), .drive_enable(drive_enable),
  .char_icon_enable(char_icon_enable), .mem_hold(mem_hold));

// >>> tb/lip_host_model.sv
module lip_host_model (
  input  wire logic       core_clk,
  output logic            bus_wr,
  output logic            bus_rd,
  output logic            register_select,
  output logic [7:0]      bus_wdata,
  input  wire logic [7:0] bus_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    bus_wr = 1'h0;
    bus_rd = 1'h0;
    register_select = 1'h0;
    bus_wdata = 8'h00;
  end
  // one strobe; released lines show inverted data so stale values never match
  task automatic put(input logic rs, input logic [7:0] b);
    @(posedge core_clk);
    bus_wr <= 1'h1;
    register_select <= rs;
    bus_wdata <= b;
    @(posedge core_clk);
    bus_wr <= 1'h0;
    register_select <= ~rs;
    bus_wdata <= ~b;
  endtask
  // 4-bit mode: upper nibble first, unwired low lines sit at the pull-up level
  task automatic wr(input logic rs, input logic [7:0] b, input logic nib);
    if (nib) begin
      put(rs, {b[7:4], 4'hF});
      put(rs, {b[3:0], 4'hF});
    end else
      put(rs, b);
  endtask
  task automatic rd(output logic [7:0] d);
    @(posedge core_clk);
    bus_rd <= 1'h1;
    @(posedge core_clk);
    bus_rd <= 1'h0;
    #1 d = bus_rdata;
  endtask
  // poll busy before any write, both halves in 4-bit mode
  task automatic wait_idle(input logic nib, output logic ok);
    logic [7:0] hi;
    logic [7:0] lo;
    ok = 1'h0;
    for (int i = 0; i < 16 && !ok; i++) begin
      rd(hi);
      if (nib)
        rd(lo);
      ok = !hi[7];
    end
  endtask
endmodule

// >>> tb/lip_ctrl_bench.sv
module lip_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       core_clk, sys_rst, bus_wr, bus_rd, register_select, instr_valid, iface_8bit, powerdown_bit, nib;
  logic       instr_rs, frame_start;
  logic [4:0] com_row;
  logic       main_osc_clk, sub_osc_clk, drive_enable, char_icon_enable, static_seg_enable, mem_hold;
  logic [7:0] bus_wdata, bus_rdata, instr_data, d, d2;
  logic [6:0] bias_ratio_x10;
  logic [3:0] contrast_step;
  int         errors, n_compared;

  lip_ctrl i_lip_ctrl (.core_clk(core_clk), .sys_rst(sys_rst), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .register_select(register_select), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .instr_valid(instr_valid),
    .instr_rs(instr_rs), .instr_data(instr_data), .iface_8bit(iface_8bit), .powerdown_bit(powerdown_bit),
    .contrast_step(contrast_step), .main_osc_clk(main_osc_clk), .sub_osc_clk(sub_osc_clk),
    .drive_enable(drive_enable), .char_icon_enable(char_icon_enable), .static_seg_enable(static_seg_enable),
    .mem_hold(mem_hold), .com_row(com_row), .frame_start(frame_start), .bias_ratio_x10(bias_ratio_x10));
  lip_host_model i_lip_host_model (.core_clk(core_clk), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .register_select(register_select), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));

  // 100 ns period
  always #50 core_clk = ~core_clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // poll until idle; a poll that runs out is a mismatch and ends the run
  task automatic idle();
    logic ok;
    i_lip_host_model.wait_idle(nib, ok);
    chk({15'h0, ok}, 16'h1);
    if (!ok)
      wrap_up();
  endtask

  // wait for idle, write one unit, then look at the executed pulse
  task automatic send(input logic rs, input logic [7:0] b);
    idle();
    i_lip_host_model.wr(rs, b, nib);
    #1;
    chk({15'h0, instr_valid}, 16'h1);
    chk({8'h0, instr_data}, {8'h0, b});
    chk({15'h0, instr_rs}, {15'h0, rs});
  endtask

  // count high samples of both oscillators over a window of whole periods
  task automatic highs(input int cyc, output logic [15:0] m, output logic [15:0] s);
    m = 16'h0;
    s = 16'h0;
    repeat (cyc) begin
      @(posedge core_clk);
      #1;
      m += main_osc_clk;
      s += sub_osc_clk;
    end
  endtask

  task automatic t_reset();
    @(posedge core_clk);
    #1;
    chk({12'h0, iface_8bit, powerdown_bit, static_seg_enable, drive_enable}, 16'hF);
    chk({12'h0, contrast_step}, 16'h0);
    chk({9'h0, bias_ratio_x10}, 16'(lip_pkg::BIAS_X10));
  endtask

  // 8-bit setup, then the switch to 4-bit with the repeated instruction
  task automatic t_init();
    send(1'h0, 8'h34);
    send(1'h0, 8'h0C);
    send(1'h0, 8'h06);
    send(1'h1, 8'hA5);
    idle();
    i_lip_host_model.put(1'h0, 8'h2F);
    #1;
    chk({15'h0, iface_8bit}, 16'h0);
    nib = 1'h1;
    idle();
    i_lip_host_model.put(1'h0, 8'h2F);
    #1;
    chk({15'h0, instr_valid}, 16'h0);
    i_lip_host_model.put(1'h0, 8'h4F);
    #1;
    chk({7'h0, instr_valid, instr_data}, 16'h0124);
  endtask

  task automatic t_contrast();
    send(1'h0, 8'h4F);
    chk({12'h0, contrast_step}, 16'hF);
    i_lip_host_model.rd(d);
    i_lip_host_model.rd(d2);
    chk({15'h0, d[7]}, 16'h1);
    chk({8'h0, d2}, 16'h0010);
    send(1'h0, 8'h40);
    chk({12'h0, contrast_step}, 16'h0);
  endtask

  // two whole frames of the row scan: one start pulse per 28 rows
  task automatic t_scan();
    logic [15:0] n;
    logic [4:0]  top;
    n = 16'h0;
    top = 5'h00;
    repeat (4 * lip_pkg::DUTY_ROWS * lip_pkg::OSC_HALF_CYC) begin
      @(posedge core_clk);
      #1;
      n += frame_start;
      if (com_row > top)
        top = com_row;
    end
    chk(n, 16'h2);
    chk({11'h0, top}, 16'(lip_pkg::DUTY_ROWS - 1));
  endtask

  task automatic t_power();
    logic [15:0] m, s;
    highs(20 * lip_pkg::OSC_HALF_CYC, m, s);
    chk(m, 16'(10 * lip_pkg::OSC_HALF_CYC));
    chk(s, 16'h0);
    send(1'h0, 8'h20);
    chk({11'h0, static_seg_enable, drive_enable, char_icon_enable, mem_hold, powerdown_bit}, 16'h12);
    send(1'h1, 8'h55);
    chk({15'h0, powerdown_bit}, 16'h0);
    chk({11'h0, com_row}, 16'h0);
    highs(4 * lip_pkg::SUB_HALF_CYC, m, s);
    chk(m, 16'h0);
    chk(s, 16'(2 * lip_pkg::SUB_HALF_CYC));
    send(1'h0, 8'h24);
    chk({11'h0, static_seg_enable, drive_enable, char_icon_enable, mem_hold, powerdown_bit}, 16'h1D);
  endtask

  // reset for 8 cycles, then the scenarios in order
  initial begin
    core_clk = 1'h0;
    sys_rst = 1'h1;
    nib = 1'h0;
    errors = 0;
    n_compared = 0;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'h0;
    t_reset();
    t_init();
    t_contrast();
    t_scan();
    t_power();
    wrap_up();
  end
endmodule
